// ===== core/ppi_regs.vh
// Constants for the printer parallel input port
`ifndef PPI_REGS_VH
`define PPI_REGS_VH
`define PPI_CLK_HZ       10000000
`define PPI_ACK_NS       5000
`define PPI_ACK_CYC      ((`PPI_ACK_NS * (`PPI_CLK_HZ / 1000000) + 999) / 1000)
`define PPI_ST_IDLE      2'h0
`define PPI_ST_HELD      2'h1
`define PPI_ST_DONE      2'h2
`define PPI_ST_ACK       2'h3
`endif

// ===== core/ppi_pulse.v
// Acknowledge pulse timer: fixed-width low pulse on a start request
`timescale 1ns/1ns
module ppi_pulse
#(
	parameter WIDTH = 50
)
(
	input  wire clk,
	input  wire rst_n,
	input  wire start,
	output reg  ack_n,
	output wire busy
);
	reg [15:0] cnt_r;

	assign busy = (cnt_r != 16'h0000);

	// Counter holds the pulse low for WIDTH cycles; restart ignored while running
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= 16'h0000;
			ack_n <= 1'b1;
		end
		else if (start && !busy)
		begin
			cnt_r <= WIDTH[15:0];
			ack_n <= 1'b0;
		end
		else if (busy)
		begin
			cnt_r <= cnt_r - 16'h0001;
			ack_n <= (cnt_r == 16'h0001);
		end
	end
endmodule

// ===== core/ppi_port.v
// Host parallel input port: strobe capture, busy, notify, processor read, acknowledge
// Contract
// - Strobe falling edge captures data lines into the holding register.
// - Busy goes high in the same step as the capture.
// - Capture raises the receive-notify output to the processor.
// - Processor reads with low read strobe; port drives held byte meanwhile.
// - Processing done drops busy and sends one low acknowledge pulse.
// - Busy stays high while the receive buffer reports full.
// - Low prime input requests re-initialization without resetting the processor.
// - Port resets at power-on, then again on the interface-chip reset line.
// - End of initialization sends one acknowledge to announce readiness.
`timescale 1ns/1ns
`include "ppi_regs.vh"
module ppi_port
#(
	parameter ACK_CYC = `PPI_ACK_CYC
)
(
	input  wire       CLK,
	input  wire       ARST_N,
	input  wire [7:0] HOST_DATA,
	input  wire       HOST_STROBE_N,
	output reg        HOST_BUSY,
	output wire       HOST_ACK_N,
	input  wire       HOST_PRIME_N,
	output reg        INIT_REQ,
	input  wire       INTERFACE_CHIP_RESET_N,
	input  wire       CPU_RD_N,
	output reg  [7:0] CPU_DATA,
	output wire       CPU_DATA_OE_N,
	output reg        RX_NOTIFY,
	input  wire       PROC_DONE,
	input  wire       BUF_FULL,
	input  wire       INIT_DONE
);
	// Reset chain, pin synchronisers, byte holding and sequence state
	reg        arst_a_r;
	reg        arst_b_r;
	reg  [1:0] ifrst_sync_r;
	reg  [2:0] stb_sync_r;
	reg  [1:0] prime_sync_r;
	reg  [1:0] rd_sync_r;
	reg        rd_prev_r;
	reg        prime_prev_r;
	reg  [7:0] data_sync_a_r;
	reg  [7:0] data_sync_b_r;
	reg  [7:0] hold_r;
	reg  [1:0] state_r;
	reg  [1:0] state_nxt;
	reg        ack_go;
	wire       rst_n;
	wire       stb_fall;
	wire       rd_act;
	wire       rd_end;
	wire       pulse_busy;

	// Power-on reset released through two flip-flops
	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			arst_a_r <= 1'b0;
			arst_b_r <= 1'b0;
		end
		else
		begin
			arst_a_r <= 1'b1;
			arst_b_r <= arst_a_r;
		end
	end

	// Interface-chip reset line synchronised; only acts once power-on reset is over
	always @(posedge CLK or negedge arst_b_r)
	begin
		if (!arst_b_r)
			ifrst_sync_r <= 2'h3;
		else
			ifrst_sync_r <= {ifrst_sync_r[0], INTERFACE_CHIP_RESET_N};
	end

	// Either reset source holds the whole port in reset
	assign rst_n = arst_b_r & ifrst_sync_r[1];

	// Pin synchronisers; first stage feeds only the second
	always @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stb_sync_r   <= 3'h7;
			prime_sync_r <= 2'h3;
			rd_sync_r    <= 2'h3;
			data_sync_a_r <= 8'h00;
			data_sync_b_r <= 8'h00;
			rd_prev_r    <= 1'b1;
			prime_prev_r <= 1'b1;
		end
		else
		begin
			stb_sync_r   <= {stb_sync_r[1:0], HOST_STROBE_N};
			prime_sync_r <= {prime_sync_r[0], HOST_PRIME_N};
			rd_sync_r    <= {rd_sync_r[0], CPU_RD_N};
			data_sync_a_r <= HOST_DATA; // Same depth as strobe; host must hold data two cycles
			data_sync_b_r <= data_sync_a_r;
			rd_prev_r    <= rd_sync_r[1];
			prime_prev_r <= prime_sync_r[1];
		end
	end

	// Falling-edge decode, shared by the strobe and prime paths
	function fall_seen;
		input prev_lvl;
		input now_lvl;
		begin
			fall_seen = prev_lvl & ~now_lvl;
		end
	endfunction

	// Edges taken from the settled second stage, never the first
	assign stb_fall = fall_seen(stb_sync_r[2], stb_sync_r[1]);
	assign rd_act   = ~rd_sync_r[1];
	assign rd_end   = ~rd_prev_r & rd_sync_r[1];

	// Prime request: pulse to the processor, no hardware reset applied
	always @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
			INIT_REQ <= 1'b0;
		else
			INIT_REQ <= fall_seen(prime_prev_r, prime_sync_r[1]);
	end

	// Byte handling sequence
	always @*
	begin
		state_nxt = state_r;
		ack_go    = 1'b0;
		case (state_r)
		// Strobes outside idle are ignored, so a held byte is never overwritten
		`PPI_ST_IDLE:
			if (stb_fall)
				state_nxt = `PPI_ST_HELD;
		// Processor read ends on the rising read strobe
		`PPI_ST_HELD:
			if (rd_end)
				state_nxt = `PPI_ST_DONE;
		`PPI_ST_DONE:
			// Full buffer keeps busy high and withholds the acknowledge
			if (PROC_DONE && !BUF_FULL)
			begin
				state_nxt = `PPI_ST_ACK;
				ack_go    = 1'b1;
			end
		// Next byte only once the pulse has run out
		`PPI_ST_ACK:
			if (!pulse_busy)
				state_nxt = `PPI_ST_IDLE;
		default:
			state_nxt = `PPI_ST_IDLE;
		endcase
		if (INIT_DONE && state_r == `PPI_ST_IDLE)
			ack_go = 1'b1;
	end

	// State, holding register, busy and notify
	always @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r   <= `PPI_ST_IDLE;
			hold_r    <= 8'h00;
			HOST_BUSY <= 1'b0;
			RX_NOTIFY <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == `PPI_ST_IDLE && stb_fall)
			begin
				hold_r    <= data_sync_b_r;
				HOST_BUSY <= 1'b1;
				RX_NOTIFY <= 1'b1;
			end
			if (state_r == `PPI_ST_HELD && rd_end)
				RX_NOTIFY <= 1'b0;
			// Acknowledge clears busy first; a full buffer forces it back high
			if (state_r == `PPI_ST_DONE && ack_go)
				HOST_BUSY <= 1'b0;
			else if (BUF_FULL)
				HOST_BUSY <= 1'b1;
			else if (state_r == `PPI_ST_IDLE && !stb_fall)
				HOST_BUSY <= 1'b0;
		end
	end

	// Read data register; bus driven only during a read
	always @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
			CPU_DATA <= 8'h00;
		else
			CPU_DATA <= hold_r;
	end

	// Drive enable follows the synchronised read strobe, low while driving
	assign CPU_DATA_OE_N = ~rd_act;

	// Acknowledge pulse timer
	ppi_pulse
	#(
		.WIDTH (ACK_CYC)
	)
	u_ack
	(
		.clk   (CLK),
		.rst_n (rst_n),
		.start (ack_go),
		.ack_n (HOST_ACK_N),
		.busy  (pulse_busy)
	);
endmodule

// ===== testbench/ppi_port_properties.sv
// Checker for the printer parallel input port
`timescale 1ns/1ns
module ppi_port_properties #(parameter ACK_CYC = 50) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic INTERFACE_CHIP_RESET_N,
	input wire logic HOST_STROBE_N,
	input wire logic HOST_BUSY,
	input wire logic HOST_ACK_N,
	input wire logic RX_NOTIFY,
	input wire logic CPU_RD_N,
	input wire logic CPU_DATA_OE_N,
	input wire logic PROC_DONE,
	input wire logic BUF_FULL,
	input wire logic INIT_DONE,
	input wire logic HOST_PRIME_N,
	input wire logic INIT_REQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N || !INTERFACE_CHIP_RESET_N);
	sequence s_got; HOST_BUSY && RX_NOTIFY; endsequence
	sequence s_ack; !HOST_ACK_N && !HOST_BUSY; endsequence
	sequence s_rd_idle; CPU_RD_N && $past(CPU_RD_N) && $past(CPU_RD_N, 2); endsequence
	logic [7:0] lo_r;
	// Low cycles of acknowledge, read back when it rises
	always_ff @(posedge CLK) lo_r <= HOST_ACK_N ? 8'h00 : lo_r + 8'h01;
	chk_strobe_take: assert property ($fell(HOST_STROBE_N) && !HOST_BUSY |-> ##[1:6] s_got)
		else $error("byte not taken");
	chk_read_drive: assert property ($fell(CPU_RD_N) |-> ##[1:4] !CPU_DATA_OE_N)
		else $error("bus not driven");
	chk_done_ack: assert property (PROC_DONE && !BUF_FULL && HOST_BUSY && !RX_NOTIFY |=> s_ack)
		else $error("no ack after done");
	chk_full_hold: assert property (BUF_FULL && HOST_BUSY |=> HOST_BUSY)
		else $error("busy dropped while full");
	chk_ack_width: assert property ($rose(HOST_ACK_N) |-> lo_r == ACK_CYC)
		else $error("ack width");
	chk_prime_req: assert property ($fell(HOST_PRIME_N) |-> ##[1:4] INIT_REQ)
		else $error("no init request");
	chk_init_ack: assert property (INIT_DONE && !HOST_BUSY |-> ##[1:2] !HOST_ACK_N)
		else $error("no ready ack");
	chk_read_clear: assert property ($rose(CPU_RD_N) && RX_NOTIFY |-> ##[1:5] !RX_NOTIFY)
		else $error("notify stuck");
	chk_oe_idle: assert property (s_rd_idle |-> CPU_DATA_OE_N)
		else $error("bus driven without read");
	chk_req_pulse: assert property (INIT_REQ |=> !INIT_REQ)
		else $error("init request too long");
endmodule
bind ppi_port ppi_port_properties #(.ACK_CYC(ACK_CYC)) u_chk (
	.CLK(CLK), .ARST_N(ARST_N), .INTERFACE_CHIP_RESET_N(INTERFACE_CHIP_RESET_N),
	.HOST_STROBE_N(HOST_STROBE_N), .HOST_BUSY(HOST_BUSY), .HOST_ACK_N(HOST_ACK_N),
	.RX_NOTIFY(RX_NOTIFY), .CPU_RD_N(CPU_RD_N), .CPU_DATA_OE_N(CPU_DATA_OE_N),
	.PROC_DONE(PROC_DONE), .BUF_FULL(BUF_FULL), .INIT_DONE(INIT_DONE),
	.HOST_PRIME_N(HOST_PRIME_N), .INIT_REQ(INIT_REQ));

// ===== testbench/ppi_host_model.sv
// Host side model: places a byte, then strobes it in
`timescale 1ns/1ns
module ppi_host (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [7:0] d,
	output logic      [7:0] data,
	output logic            stb_n
);
	// Data settles a cycle before strobe; lines flip once hold ends
	initial
	begin
		data = 8'h00;
		stb_n = 1'b1;
		forever
		begin
			@(posedge go);
			@(negedge clk) data = d;
			@(negedge clk) stb_n = 1'b0;
			repeat (4) @(negedge clk);
			stb_n = 1'b1;
			data = ~d;
		end
	end
endmodule

// ===== testbench/tb_printer_parallel_input_port.sv
// Bench for the printer parallel input port
`timescale 1ns/1ns
module tb_printer_parallel_input_port;
	logic CLK = 0, ARST_N = 0, HOST_PRIME_N = 1, INTERFACE_CHIP_RESET_N = 1, go = 0;
	logic CPU_RD_N = 1, PROC_DONE = 0, BUF_FULL = 0, INIT_DONE = 0;
	logic HOST_STROBE_N, HOST_BUSY, HOST_ACK_N, INIT_REQ, CPU_DATA_OE_N, RX_NOTIFY;
	logic [7:0] tx = 8'h00, HOST_DATA, CPU_DATA;
	logic [15:0] lf = 16'hfee3;
	int err_count = 0, n_checks = 0, k;
	// Clock, device and host; short ack keeps the run brief
	always #50 CLK = ~CLK;
	ppi_port #(.ACK_CYC(3)) DUT (
		.CLK(CLK), .ARST_N(ARST_N), .HOST_DATA(HOST_DATA), .HOST_STROBE_N(HOST_STROBE_N),
		.HOST_BUSY(HOST_BUSY), .HOST_ACK_N(HOST_ACK_N), .HOST_PRIME_N(HOST_PRIME_N),
		.INIT_REQ(INIT_REQ), .INTERFACE_CHIP_RESET_N(INTERFACE_CHIP_RESET_N),
		.CPU_RD_N(CPU_RD_N), .CPU_DATA(CPU_DATA), .CPU_DATA_OE_N(CPU_DATA_OE_N),
		.RX_NOTIFY(RX_NOTIFY), .PROC_DONE(PROC_DONE), .BUF_FULL(BUF_FULL),
		.INIT_DONE(INIT_DONE));
	ppi_host u_host (.clk(CLK), .go(go), .d(tx), .data(HOST_DATA), .stb_n(HOST_STROBE_N));
	function logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task chk(input string s, input logic [7:0] v, e);
		n_checks++;
		if (v !== e)
		begin
			err_count++;
			$display("wrong value %s exp %h got %h", s, e, v);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog well past the expected run
	initial
	begin
		#300000;
		err_count++;
		final_report;
	end
	// Main sequence, inputs change at falling edges
	initial
	begin
		cyc(2);
		ARST_N = 1;
		cyc(5);
		chk("idle", {HOST_BUSY, RX_NOTIFY, HOST_ACK_N}, 1);
		INIT_DONE = 1;
		cyc(1);
		INIT_DONE = 0;
		for (k = 0; k < 3 && HOST_ACK_N !== 0; k++) cyc(1);
		chk("ready", HOST_ACK_N, 0);
		cyc(6);
		for (int t = 0; t < 8; t++)
		begin
			lf = nx(lf);
			tx = (t == 0) ? 8'hff : (t == 3) ? 8'h00 : lf[7:0];
			go = 1;
			cyc(8);
			go = 0;
			chk("take", {HOST_BUSY, RX_NOTIFY}, 3);
			CPU_RD_N = 0;
			cyc(4);
			chk("read", CPU_DATA, tx);
			chk("oe", CPU_DATA_OE_N, 0);
			CPU_RD_N = 1;
			cyc(5);
			chk("clear", RX_NOTIFY, 0);
			chk("oe off", CPU_DATA_OE_N, 1);
			BUF_FULL = t[0];
			PROC_DONE = 1;
			cyc(t[0] * 4);
			chk("full", HOST_BUSY, 1);
			BUF_FULL = 0;
			for (k = 0; k < 4 && HOST_ACK_N !== 0; k++) cyc(1);
			chk("ack", {HOST_ACK_N, HOST_BUSY}, 0);
			PROC_DONE = 0;
			cyc(5);
			$display("test %0d done", t);
		end
		HOST_PRIME_N = 0;
		for (k = 0; k < 6 && INIT_REQ !== 1; k++) cyc(1);
		chk("prime", INIT_REQ, 1);
		HOST_PRIME_N = 1;
		go = 1;
		cyc(8);
		INTERFACE_CHIP_RESET_N = 0;
		cyc(4);
		chk("ifrst", {HOST_BUSY, RX_NOTIFY}, 0);
		chk("ifrst data", CPU_DATA, 8'h00);
		INTERFACE_CHIP_RESET_N = 1;
		go = 0;
		cyc(4);
		go = 1;
		cyc(8);
		go = 0;
		chk("take again", {HOST_BUSY, RX_NOTIFY}, 3);
		chk("byte again", CPU_DATA, tx);
		$display("reset test done");
		final_report;
	end
endmodule
